/* File: logic/mtc_core.sv */
`timescale 1ns/1ns
`include "mtc_regs.svh"
// Overview of operation
// [RULE1] Accumulator copies into a working register or into RAM at R0/R1, one cycle.
// [RULE2] Immediate byte loads a working register or RAM at R0/R1, two cycles.
// [RULE3] Status word moves to accumulator and back, one cycle each.
// [RULE4] Accumulator swaps with a working register or with RAM at R0/R1.
// [RULE5] Low nibbles of accumulator and RAM at R0/R1 swap; high nibbles stay.
// [RULE6] External data memory read into or written from accumulator at R0/R1.
// [RULE7] Accumulator replaced by program byte in current page or fixed page.
// [RULE8] First port loads from RAM at R3, or program byte at R3.
// [RULE9] Port output latches, not pins, copy into the accumulator.
// [RULE10] Timer interrupt enable set by 25h, cleared by 35h.
// [RULE11] External interrupt enable set by 05h, cleared by 15h.
// [RULE12] Register set select cleared by C5h, set by D5h.
// [RULE13] Program bank flop cleared by E5h, set by F5h.
// [RULE14] Jump or call takes bit 11 from the bank flop.
// [RULE15] Opcode 75h drives test pin zero with crystal over three.
// [RULE16] A2h floats ports and bus port; C2h floats control outputs.
// [RULE17] E2h ends both float conditions.
// [RULE18] 01h stops core sequencing; 82h also stops the oscillator.
// [RULE19] Timer value moves to accumulator and back, one cycle.
// [RULE20] 55h starts timer mode at crystal over 15 then 32.
// [RULE21] 45h starts counter mode on test pin one transitions; only high-to-low edges are counted.
// [RULE22] 65h stops counting and holds the value.
// [RULE23] 00h only advances the program counter.
// [RULE24] Second byte fetched at next address; counter passes both bytes.
module mtc_core (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Program memory, combinational read.
    output logic      [11:0] prog_addr,
    input  wire logic [7:0]  prog_data,
    // External data memory on the bus port.
    output logic      [7:0]  xd_addr,
    output logic      [7:0]  xd_wdata,
    output logic             xd_bus_oe,
    output logic             xd_rd,
    output logic             xd_wr,
    output logic             xd_ctl_oe,
    input  wire logic [7:0]  xd_rdata,
    // Quasi ports.
    output logic      [7:0]  first_quasi_port,
    output logic      [7:0]  second_quasi_port,
    output logic             quasi_port_oe,
    // Test pins and oscillator control.
    output logic             test_pin_zero_out,
    output logic             test_pin_zero_oe,
    input  wire logic        test_pin_one,
    output logic             oscillator_halt,
    // Register port.
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata
);
    import mtc_pkg::*;

    logic [7:0]  ram [`MTC_RAM_DEPTH];
    mtc_state_t  state_r;
    logic [11:0] pc_r;
    logic [7:0]  ir_r;
    logic [7:0]  acc_r;
    logic [7:0]  program_status_word;
    logic [7:0]  timer_val;
    logic [7:0]  ctrl_r;
    logic [1:0]  stall_r;
    logic [1:0]  t0_div_r;
    logic        timer_irq_enable;
    logic        external_irq_enable;
    logic        program_bank_flop;
    logic        test_clock_out_on;
    logic        port_float_cmd;
    logic        control_float_cmd;
    logic        core_clock_halt;
    logic        tmr_run;
    logic        cnt_run;
    logic        exec;
    logic        ram_we;
    logic [6:0]  ram_wa;
    logic [7:0]  ram_wd;
    logic [6:0]  dir_a;
    logic [6:0]  ind_a;
    logic [7:0]  r3_val;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_op(input logic [7:0] op, input logic [7:0] val,
                                   input logic [7:0] mask);
        return (op & mask) == val;
    endfunction

    function automatic logic [6:0] wreg(input logic [2:0] r, input logic bank);
        return bank ? {`MTC_BANK1_BASE, r} : {4'h0, r};
    endfunction

    function automatic logic needs_byte2(input logic [7:0] op);
        return is_op(op, `MTC_OP_MOV_RD, `MTC_M_REG) || is_op(op, `MTC_OP_MOV_ID, `MTC_M_IND)
            || is_op(op, `MTC_OP_JMP, `MTC_M_JMP) || is_op(op, `MTC_OP_CALL, `MTC_M_JMP);
    endfunction

    function automatic logic two_cycle(input logic [7:0] op);
        return needs_byte2(op) || is_op(op, `MTC_OP_XRD, `MTC_M_IND)
            || is_op(op, `MTC_OP_XWR, `MTC_M_IND) || op == `MTC_OP_LKP
            || op == `MTC_OP_LKP3 || op == `MTC_OP_P1PGM || op == `MTC_OP_P1RAM;
    endfunction

    assign exec   = state_r == ST_EXEC;
    assign dir_a  = wreg(ir_r[2:0], program_status_word[`MTC_PSW_BANK_BIT]);
    assign ind_a  = ram[wreg({2'b00, ir_r[0]}, program_status_word[`MTC_PSW_BANK_BIT])][6:0];
    assign r3_val = ram[wreg(3'h3, program_status_word[`MTC_PSW_BANK_BIT])];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_FETCH;
            stall_r <= 2'h0;
        end else begin
            unique case (state_r)
                ST_FETCH: begin
                    if (ctrl_r[`MTC_CTRL_RUN_BIT]) begin
                        state_r <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    state_r <= ST_EXEC;
                end
                ST_EXEC: begin
                    stall_r <= `MTC_CYCLE_CLKS;
                    if (ir_r == `MTC_OP_HLT || ir_r == `MTC_OP_OSCILLATOR_HALT) begin
                        state_r <= ST_HALT; // [RULE18]
                    end else if (two_cycle(ir_r)) begin
                        state_r <= ST_STALL;
                    end else begin
                        state_r <= ST_FETCH;
                    end
                end
                ST_STALL: begin
                    stall_r <= stall_r - 2'h1;
                    if (stall_r == 2'h1) begin
                        state_r <= ST_FETCH;
                    end
                end
                ST_HALT: begin
                    state_r <= ST_HALT;
                end
            endcase
        end
    end

    // Program counter and program memory address.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r      <= 12'h000;
            prog_addr <= 12'h000;
            ir_r      <= `MTC_OP_NOP;
        end else if (state_r == ST_FETCH && ctrl_r[`MTC_CTRL_RUN_BIT]) begin
            prog_addr <= pc_r;
            pc_r      <= pc_r + 12'h001; // [RULE23]
        end else if (state_r == ST_DECODE) begin
            ir_r <= prog_data;
            if (needs_byte2(prog_data)) begin
                prog_addr <= pc_r; // [RULE24]
                pc_r      <= pc_r + 12'h001; // [RULE24]
            end else if (prog_data == `MTC_OP_LKP) begin
                prog_addr <= {pc_r[11:8], acc_r}; // [RULE7]
            end else if (prog_data == `MTC_OP_LKP3) begin
                prog_addr <= {`MTC_FIXED_PAGE, acc_r}; // [RULE7]
            end else if (prog_data == `MTC_OP_P1PGM) begin
                prog_addr <= {pc_r[11:8], r3_val}; // [RULE8]
            end
        end else if (exec && (is_op(ir_r, `MTC_OP_JMP, `MTC_M_JMP)
                              || is_op(ir_r, `MTC_OP_CALL, `MTC_M_JMP))) begin
            pc_r <= {program_bank_flop, ir_r[7:5], prog_data}; // [RULE14]
        end
    end

    // External data memory strobes, set up in decode, high for one clock in the execute slot.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xd_addr   <= 8'h00;
            xd_wdata  <= 8'h00;
            xd_rd     <= 1'b0;
            xd_wr     <= 1'b0;
            xd_bus_oe <= 1'b0;
        end else begin
            xd_rd     <= 1'b0;
            xd_wr     <= 1'b0;
            xd_bus_oe <= 1'b0;
            if (state_r == ST_DECODE && is_op(prog_data, `MTC_OP_XRD, `MTC_M_IND)) begin
                xd_addr <= ram[wreg({2'b00, prog_data[0]}, program_status_word[`MTC_PSW_BANK_BIT])];
                xd_rd   <= 1'b1; // [RULE6]
            end
            if (state_r == ST_DECODE && is_op(prog_data, `MTC_OP_XWR, `MTC_M_IND)) begin
                xd_addr   <= ram[wreg({2'b00, prog_data[0]}, program_status_word[`MTC_PSW_BANK_BIT])];
                xd_wdata  <= acc_r;
                xd_wr     <= 1'b1; // [RULE6]
                xd_bus_oe <= ~port_float_cmd; // [RULE16]
            end
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    always_comb begin
        ram_we = 1'b0;
        ram_wa = dir_a;
        ram_wd = acc_r;
        if (exec) begin
            if (is_op(ir_r, `MTC_OP_MOV_RA, `MTC_M_REG) || is_op(ir_r, `MTC_OP_XCH_R, `MTC_M_REG)) begin
                ram_we = 1'b1; // [RULE1] [RULE4]
            end else if (is_op(ir_r, `MTC_OP_MOV_IA, `MTC_M_IND)
                         || is_op(ir_r, `MTC_OP_XCH_I, `MTC_M_IND)) begin
                ram_we = 1'b1; // [RULE1] [RULE4]
                ram_wa = ind_a;
            end else if (is_op(ir_r, `MTC_OP_MOV_RD, `MTC_M_REG)) begin
                ram_we = 1'b1; // [RULE2]
                ram_wd = prog_data;
            end else if (is_op(ir_r, `MTC_OP_MOV_ID, `MTC_M_IND)) begin
                ram_we = 1'b1; // [RULE2]
                ram_wa = ind_a;
                ram_wd = prog_data;
            end else if (is_op(ir_r, `MTC_OP_NIBBLE_EXCHANGE, `MTC_M_IND)) begin
                ram_we = 1'b1;
                ram_wa = ind_a;
                ram_wd = {ram[ind_a][7:4], acc_r[3:0]}; // [RULE5]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 8'h00;
        end else if (exec) begin
            if (ir_r == `MTC_OP_A_PSW) begin
                acc_r <= program_status_word; // [RULE3]
            end else if (is_op(ir_r, `MTC_OP_XCH_R, `MTC_M_REG)) begin
                acc_r <= ram[dir_a]; // [RULE4]
            end else if (is_op(ir_r, `MTC_OP_XCH_I, `MTC_M_IND)) begin
                acc_r <= ram[ind_a]; // [RULE4]
            end else if (is_op(ir_r, `MTC_OP_NIBBLE_EXCHANGE, `MTC_M_IND)) begin
                acc_r <= {acc_r[7:4], ram[ind_a][3:0]}; // [RULE5]
            end else if (is_op(ir_r, `MTC_OP_XRD, `MTC_M_IND)) begin
                acc_r <= xd_rdata; // [RULE6]
            end else if (ir_r == `MTC_OP_LKP || ir_r == `MTC_OP_LKP3) begin
                acc_r <= prog_data; // [RULE7]
            end else if (ir_r == `MTC_OP_A_P1) begin
                acc_r <= first_quasi_port; // [RULE9]
            end else if (ir_r == `MTC_OP_A_P2) begin
                acc_r <= second_quasi_port; // [RULE9]
            end else if (ir_r == `MTC_OP_A_T) begin
                acc_r <= timer_val; // [RULE19]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_status_word <= 8'h00;
        end else if (exec && ir_r == `MTC_OP_PSW_A) begin
            program_status_word <= acc_r; // [RULE3]
        end else if (exec && ir_r == `MTC_OP_BS0) begin
            program_status_word[`MTC_PSW_BANK_BIT] <= 1'b0; // [RULE12]
        end else if (exec && ir_r == `MTC_OP_BS1) begin
            program_status_word[`MTC_PSW_BANK_BIT] <= 1'b1; // [RULE12]
        end
    end

    // First port load from RAM or program memory; second port holds its latch.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_quasi_port  <= 8'hFF;
            second_quasi_port <= 8'hFF;
        end else if (exec && ir_r == `MTC_OP_P1RAM) begin
            first_quasi_port <= ram[r3_val[6:0]]; // [RULE8]
        end else if (exec && ir_r == `MTC_OP_P1PGM) begin
            first_quasi_port <= prog_data; // [RULE8]
        end
    end

    // ------------------------------------------------------------
    // Control flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_enable    <= 1'b0;
            external_irq_enable <= 1'b0;
            program_bank_flop   <= 1'b0;
            test_clock_out_on   <= 1'b0;
        end else if (exec) begin
            if (ir_r == `MTC_OP_TIE) timer_irq_enable <= 1'b1; // [RULE10]
            if (ir_r == `MTC_OP_TID) timer_irq_enable <= 1'b0; // [RULE10]
            if (ir_r == `MTC_OP_XIE) external_irq_enable <= 1'b1; // [RULE11]
            if (ir_r == `MTC_OP_XID) external_irq_enable <= 1'b0; // [RULE11]
            if (ir_r == `MTC_OP_MB0) program_bank_flop <= 1'b0; // [RULE13]
            if (ir_r == `MTC_OP_MB1) program_bank_flop <= 1'b1; // [RULE13]
            if (ir_r == `MTC_OP_T0CLK) test_clock_out_on <= 1'b1; // [RULE15]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_float_cmd    <= 1'b0;
            control_float_cmd <= 1'b0;
            quasi_port_oe     <= 1'b0;
            xd_ctl_oe         <= 1'b0;
        end else begin
            quasi_port_oe <= ~port_float_cmd;
            xd_ctl_oe     <= ~control_float_cmd;
            if (exec && ir_r == `MTC_OP_PFLT) port_float_cmd <= 1'b1; // [RULE16]
            if (exec && ir_r == `MTC_OP_CFLT) control_float_cmd <= 1'b1; // [RULE16]
            if (exec && ir_r == `MTC_OP_FLOAT_CANCEL_CMD) begin
                port_float_cmd    <= 1'b0; // [RULE17]
                control_float_cmd <= 1'b0; // [RULE17]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clock_halt <= 1'b0;
            oscillator_halt <= 1'b0;
        end else if (exec && ir_r == `MTC_OP_HLT) begin
            core_clock_halt <= 1'b1; // [RULE18]
        end else if (exec && ir_r == `MTC_OP_OSCILLATOR_HALT) begin
            core_clock_halt <= 1'b1;
            oscillator_halt <= 1'b1; // [RULE18]
        end
    end

    // Test pin zero clock: high one clock in three.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t0_div_r          <= 2'h0;
            test_pin_zero_out <= 1'b0;
            test_pin_zero_oe  <= 1'b0;
        end else begin
            t0_div_r          <= (t0_div_r == `MTC_T0_DIV - 2'h1) ? 2'h0 : t0_div_r + 2'h1;
            test_pin_zero_out <= test_clock_out_on && t0_div_r == 2'h0; // [RULE15]
            test_pin_zero_oe  <= test_clock_out_on;
        end
    end

    mtc_timer u_timer (
        .clk          (clk),
        .rst_n        (rst_n),
        .test_pin_one (test_pin_one),
        .load         (exec && ir_r == `MTC_OP_T_A),
        .load_val     (acc_r),
        .start_tmr    (exec && ir_r == `MTC_OP_STRT),
        .start_cnt    (exec && ir_r == `MTC_OP_CNT),
        .stop         (exec && ir_r == `MTC_OP_STOP),
        .count        (timer_val),
        .tmr_run      (tmr_run),
        .cnt_run      (cnt_run)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `MTC_CTRL_RESET;
        end else if (reg_wr && reg_addr == `MTC_REG_CTRL) begin
            ctrl_r <= {7'h00, reg_wdata[`MTC_CTRL_RUN_BIT]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `MTC_REG_CTRL:  reg_rdata <= ctrl_r;
                `MTC_REG_ACC:   reg_rdata <= acc_r;
                `MTC_REG_PSW:   reg_rdata <= program_status_word;
                `MTC_REG_TIMER: reg_rdata <= timer_val;
                `MTC_REG_FLAGS: reg_rdata <= {cnt_run, tmr_run, core_clock_halt,
                                              control_float_cmd, port_float_cmd,
                                              program_bank_flop, external_irq_enable,
                                              timer_irq_enable};
                `MTC_REG_PCL:   reg_rdata <= pc_r[7:0];
                `MTC_REG_PCH:   reg_rdata <= {4'h0, pc_r[11:8]};
                `MTC_REG_PORT1: reg_rdata <= first_quasi_port;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

/* File: logic/mtc_regs.svh */
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

// Register port offsets.
`define MTC_REG_CTRL       3'h0
`define MTC_REG_ACC        3'h1
`define MTC_REG_PSW        3'h2
`define MTC_REG_TIMER      3'h3
`define MTC_REG_FLAGS      3'h4
`define MTC_REG_PCL        3'h5
`define MTC_REG_PCH        3'h6
`define MTC_REG_PORT1      3'h7
`define MTC_CTRL_RUN_BIT   0
`define MTC_CTRL_RESET     8'h01

// Field positions and memory layout.
`define MTC_PSW_BANK_BIT   4
`define MTC_RAM_DEPTH      128
`define MTC_BANK1_BASE     4'h3
`define MTC_FIXED_PAGE     4'h3

// Timing counts in clock cycles.
`define MTC_CYCLE_CLKS     2'h3
`define MTC_T0_DIV         2'h3
`define MTC_TMR_PRE        4'hF
`define MTC_TMR_POST       6'h20

// Opcode values and match masks.
`define MTC_M_ALL     8'hFF
`define MTC_M_REG     8'hF8
`define MTC_M_IND     8'hFE
`define MTC_M_JMP     8'h1F
`define MTC_OP_MOV_RA 8'hA8
`define MTC_OP_MOV_IA 8'hA0
`define MTC_OP_MOV_RD 8'hB8
`define MTC_OP_MOV_ID 8'hB0
`define MTC_OP_A_PSW  8'hC7
`define MTC_OP_PSW_A  8'hD7
`define MTC_OP_XCH_R  8'h28
`define MTC_OP_XCH_I  8'h20
`define MTC_OP_NIBBLE_EXCHANGE   8'h30
`define MTC_OP_XRD    8'h80
`define MTC_OP_XWR    8'h90
`define MTC_OP_LKP    8'hA3
`define MTC_OP_LKP3   8'hE3
`define MTC_OP_P1PGM  8'hC3
`define MTC_OP_P1RAM  8'hF3
`define MTC_OP_A_P1   8'h63
`define MTC_OP_A_P2   8'h73
`define MTC_OP_TIE    8'h25
`define MTC_OP_TID    8'h35
`define MTC_OP_XIE    8'h05
`define MTC_OP_XID    8'h15
`define MTC_OP_BS0    8'hC5
`define MTC_OP_BS1    8'hD5
`define MTC_OP_MB0    8'hE5
`define MTC_OP_MB1    8'hF5
`define MTC_OP_T0CLK  8'h75
`define MTC_OP_PFLT   8'hA2
`define MTC_OP_CFLT   8'hC2
`define MTC_OP_FLOAT_CANCEL_CMD   8'hE2
`define MTC_OP_HLT    8'h01
`define MTC_OP_OSCILLATOR_HALT  8'h82
`define MTC_OP_A_T    8'h42
`define MTC_OP_T_A    8'h62
`define MTC_OP_STRT   8'h55
`define MTC_OP_CNT    8'h45
`define MTC_OP_STOP   8'h65
`define MTC_OP_NOP    8'h00
`define MTC_OP_JMP    8'h04
`define MTC_OP_CALL   8'h14

`endif

/* File: logic/mtc_pkg.sv */
package mtc_pkg;
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_DECODE,
        ST_EXEC,
        ST_STALL,
        ST_HALT
    } mtc_state_t;
endpackage

/* File: logic/mtc_timer.sv */
`timescale 1ns/1ns
`include "mtc_regs.svh"
module mtc_timer (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Test pin one, asynchronous.
    input  wire logic       test_pin_one,
    // Commands from the decoder.
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       start_tmr,
    input  wire logic       start_cnt,
    input  wire logic       stop,
    // State.
    output logic      [7:0] count,
    output logic            tmr_run,
    output logic            cnt_run
);
    logic [3:0] pre_r;
    logic [5:0] post_r;
    logic       t1_s1_r;
    logic       t1_s2_r;
    logic       t1_d_r;
    logic       tick;
    logic       t1_fall;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t1_s1_r <= 1'b0;
            t1_s2_r <= 1'b0;
            t1_d_r  <= 1'b0;
        end else begin
            t1_s1_r <= test_pin_one;
            t1_s2_r <= t1_s1_r;
            t1_d_r  <= t1_s2_r;
        end
    end

    assign t1_fall = t1_d_r & ~t1_s2_r;

    // Crystal divided by 15, then by 32, gives the timer tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r  <= 4'h0;
            post_r <= 6'h00;
        end else if (start_tmr) begin
            pre_r  <= 4'h0;
            post_r <= 6'h00;
        end else if (tmr_run) begin
            pre_r <= (pre_r == `MTC_TMR_PRE - 4'h1) ? 4'h0 : pre_r + 4'h1;
            if (pre_r == `MTC_TMR_PRE - 4'h1) begin
                post_r <= (post_r == `MTC_TMR_POST - 6'h01) ? 6'h00 : post_r + 6'h01;
            end
        end
    end

    assign tick = tmr_run && pre_r == `MTC_TMR_PRE - 4'h1 && post_r == `MTC_TMR_POST - 6'h01;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_run <= 1'b0;
            cnt_run <= 1'b0;
        end else if (stop) begin
            tmr_run <= 1'b0; // [RULE22]
            cnt_run <= 1'b0; // [RULE22]
        end else if (start_tmr) begin
            tmr_run <= 1'b1; // [RULE20]
            cnt_run <= 1'b0;
        end else if (start_cnt) begin
            cnt_run <= 1'b1; // [RULE21]
            tmr_run <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (load) begin
            count <= load_val; // [RULE19]
        end else if (tick || (cnt_run && t1_fall)) begin
            count <= count + 8'h01; // [RULE20] [RULE21]
        end
    end
endmodule

/* File: sim/mtc_mem_model.sv */
`timescale 1ns/1ns
module mtc_mem_model (
    // Clock.
    input  wire logic        clk,
    // Program memory.
    input  wire logic [11:0] prog_addr,
    output logic      [7:0]  prog_data,
    // External data memory.
    input  wire logic [7:0]  xd_addr,
    input  wire logic [7:0]  xd_wdata,
    input  wire logic        xd_rd,
    input  wire logic        xd_wr,
    output logic      [7:0]  xd_rdata
);
    logic [7:0] rom [4096];
    logic [7:0] ram [256];
    assign prog_data = rom[prog_addr];
    // Outside a read strobe the bus shows the inverse, so stale data never passes for good.
    assign xd_rdata = xd_rd ? ram[xd_addr] : ~ram[xd_addr];
    always @(posedge clk) if (xd_wr) ram[xd_addr] <= xd_wdata;
endmodule

/* File: sim/mtc_core_sva.sv */
`timescale 1ns/1ns
module mtc_core_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Bus port and pins.
    input wire logic xd_rd,
    input wire logic xd_wr,
    input wire logic xd_bus_oe,
    input wire logic quasi_port_oe,
    input wire logic test_pin_zero_out,
    input wire logic test_pin_zero_oe,
    input wire logic oscillator_halt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rd_pulse: assert property (xd_rd |=> !xd_rd) else $error("long read strobe");
    a_wr_pulse: assert property (xd_wr |=> !xd_wr) else $error("long write strobe");
    a_wr_drives: assert property (xd_wr && quasi_port_oe |-> xd_bus_oe) else $error("bus idle");
    a_oe_with_wr: assert property (xd_bus_oe |-> xd_wr) else $error("bus driven alone");
    a_float_bus: assert property (!quasi_port_oe |-> !xd_bus_oe) else $error("floated bus");
    a_tclk_third: assert property (test_pin_zero_out |=> !test_pin_zero_out [*2] ##1
        test_pin_zero_out) else $error("test clock not a third");
    a_tclk_oe: assert property (test_pin_zero_out |-> test_pin_zero_oe) else $error("pin off");
    a_osc_stays: assert property (oscillator_halt |=> oscillator_halt) else $error("osc woke");
endmodule
bind mtc_core mtc_core_sva i_mtc_core_sva (.clk, .rst_n, .xd_rd, .xd_wr, .xd_bus_oe,
    .quasi_port_oe, .test_pin_zero_out, .test_pin_zero_oe, .oscillator_halt);

/* File: sim/mtc_core_tb.sv */
`timescale 1ns/1ns
module mtc_core_tb;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, t1 = 0;
    logic [2:0]  reg_addr = 0;
    logic [7:0]  reg_wdata = 0, reg_rdata, prog_data, xd_rdata, xd_addr, xd_wdata, got;
    logic [11:0] prog_addr;
    logic        xd_bus_oe, xd_rd, xd_wr, xd_ctl_oe, quasi_port_oe, oscillator_halt;
    logic        test_pin_zero_out, test_pin_zero_oe;
    int          err_total = 0, compares = 0;
    always #4 clk = ~clk;
    mtc_core i_mtc_core (.clk, .rst_n, .prog_addr, .prog_data, .xd_addr, .xd_wdata, .xd_bus_oe,
        .xd_rd, .xd_wr, .xd_ctl_oe, .xd_rdata, .first_quasi_port(), .second_quasi_port(),
        .quasi_port_oe, .test_pin_zero_out, .test_pin_zero_oe, .test_pin_one(t1),
        .oscillator_halt, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    mtc_mem_model i_mtc_mem_model (.clk, .prog_addr, .prog_data, .xd_addr, .xd_wdata, .xd_rd,
        .xd_wr, .xd_rdata);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic run(input logic [7:0] p [$], input int n);
        rst_n <= 0;
        foreach (i_mtc_mem_model.rom[k]) i_mtc_mem_model.rom[k] = 8'h00;
        foreach (p[k]) i_mtc_mem_model.rom[k] = p[k];
        repeat (10) @(posedge clk);
        rst_n <= 1;
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 got = reg_rdata;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic t_moves();
        run('{8'hB8, 8'h5A, 8'h28, 8'hB9, 8'h20, 8'hA1, 8'hB8, 8'hC3, 8'h28, 8'h31}, 40);
        rd(1); chk(got, 8'hCA);
        wr(1, 8'h00);
        rd(1); chk(got, 8'hCA);
        $display("moves done");
    endtask
    task automatic t_xdata();
        i_mtc_mem_model.ram[8'h44] = 8'h9E;
        run('{8'hB8, 8'h33, 8'hB9, 8'h77, 8'h29, 8'h90, 8'hB8, 8'h44, 8'h80}, 45);
        chk(i_mtc_mem_model.ram[8'h33], 8'h77);
        rd(1); chk(got, 8'h9E);
        $display("external data done");
    endtask
    task automatic t_ctrl();
        run('{8'h00, 8'h25, 8'h05, 8'hD5, 8'hF5, 8'hA2, 8'hC2}, 30);
        rd(4); chk(got, 8'h1F);
        rd(2); chk({7'h0, got[4]}, 8'h01);
        chk({6'h0, quasi_port_oe, xd_ctl_oe}, 8'h00);
        run('{8'h00, 8'h25, 8'h05, 8'hD5, 8'hF5, 8'hA2, 8'hC2, 8'h35, 8'h15, 8'hE5, 8'hE2,
            8'hC5, 8'h75, 8'h01}, 50);
        rd(4); chk(got, 8'h20);
        rd(2); chk({7'h0, got[4]}, 8'h00);
        rd(5); chk(got, 8'h0E);
        chk({5'h0, quasi_port_oe, xd_ctl_oe, test_pin_zero_oe}, 8'h07);
        run('{8'h82}, 10);
        chk({7'h0, oscillator_halt}, 8'h01);
        $display("control done");
    endtask
    task automatic t_timer();
        run('{8'hB8, 8'hFE, 8'h28, 8'h62, 8'h55}, 100);
        i_mtc_mem_model.rom[256] = 8'h65;
        i_mtc_mem_model.rom[257] = 8'h42;
        rd(3); chk(got, 8'hFE);
        repeat (480) @(posedge clk);
        rd(3); chk(got, 8'hFF);
        repeat (800) @(posedge clk);
        rd(3); chk(got, 8'hFF);
        rd(1); chk(got, 8'hFF);
        $display("timer done");
    endtask
    task automatic t_count();
        run('{8'h45}, 10);
        repeat (3) begin
            t1 <= 1;
            repeat (2) @(posedge clk);
            t1 <= 0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rd(3); chk(got, 8'h03);
        $display("counter done");
    endtask
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        t_moves();
        t_xdata();
        t_ctrl();
        t_timer();
        t_count();
        end_sim();
    end
endmodule
